// ==== core/eicp_pkg.sv ====
// package for the external interrupt, core clock mode and pll settings bank
// assumes a 32-bit avalon-mm slave with byte addresses
package eicp_pkg;
    // ==================================================
    // register offsets (byte addresses)
    localparam logic [7:0]  EICP_OFS_TRIG      = 8'h80;
    localparam logic [7:0]  EICP_OFS_CLR       = 8'h84;
    localparam logic [7:0]  EICP_OFS_CORE      = 8'h88;
    localparam logic [7:0]  EICP_OFS_SYSPLL    = 8'hc0;
    localparam logic [7:0]  EICP_OFS_USBPLL    = 8'hc4;
    // ==================================================
    // reset values
    localparam logic [15:0] EICP_TRIG_RST      = 16'h0000;
    localparam logic [1:0]  EICP_CORE_RST      = 2'h0;
    localparam logic [13:0] EICP_PLL_RST       = 14'h2045;
    // ==================================================
    // pll field positions
    localparam int          EICP_PLL_RANGE_BIT = 12;
    localparam int          EICP_PLL_KEEP_BIT  = 13;
    localparam int          EICP_PLL_PRE_LSB   = 6;
    localparam int          EICP_PLL_LOOP_LSB  = 0;
    localparam int          EICP_PLL_FLD_W     = 6;
    // ==================================================
    // trigger field encodings
    localparam logic [1:0]  EICP_TRIG_LVL_LOW  = 2'h0;
    localparam logic [1:0]  EICP_TRIG_LVL_HIGH = 2'h1;
    localparam logic [1:0]  EICP_TRIG_FALL     = 2'h2;
    localparam logic [1:0]  EICP_TRIG_RISE     = 2'h3;
    // ==================================================
    // core clock mode encodings
    localparam logic [1:0]  EICP_CORE_STD_ASYNC = 2'h0;
    localparam logic [1:0]  EICP_CORE_STD_SYNC  = 2'h2;
    localparam logic [31:0] EICP_RD_UNMAPPED    = 32'h0000_0000;
endpackage

// ==== core/eicp_top.sv ====
// register bank: external interrupt triggering, edge clear, core clock mode, pll controls
// assumes avalon-mm master on sys_clk; interrupt pins already synchronous
//
// How it works
// - trigger configuration resets to zero: all inputs level, active low
// - input n uses trigger field bits 2n+1 down to 2n
// - 00 level low, 01 level high, 10 falling edge, 11 rising edge
// - writing 1 to clear bit n drops pending edge request n
// - clear writes do not touch level configured inputs
// - clear register write only; bits 31 to 8 ignored
// - core mode 00 std async, 10 std sync, x1 direct extension
// - system pll frequency is osc times loop over pre, max 304.819 MHz
// - system pll bit 12 selects high range when one
// - system loop divider bits 5 to 0, values 1 to 63; a written 0 is stored and passed on unchecked
// - usb pll is osc times loop over pre; bit 12 selects range
// - usb pll bits 31 to 14 ignore writes and read zero
// - usb loop divider bits 5 to 0, values 1 to 63; a written 0 is stored and passed on unchecked
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module eicp_top
    import eicp_pkg::*;
#(
    parameter int N_IRQ = 8
)(
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic [7:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic [N_IRQ-1:0]          ext_irq_pin,
    output logic      [N_IRQ-1:0]          ext_irq_request,
    output logic      [1:0]                core_clocking_select,
    output logic                           core_direct_bus_extension_mode,
    output logic                           core_std_sync_mode,
    output logic                           system_pll_range_select,
    output logic      [EICP_PLL_FLD_W-1:0] system_pll_pre_divider,
    output logic      [EICP_PLL_FLD_W-1:0] system_pll_loop_divider,
    output logic                           usb_pll_range_select,
    output logic      [EICP_PLL_FLD_W-1:0] usb_pll_pre_divider,
    output logic      [EICP_PLL_FLD_W-1:0] usb_pll_loop_divider
);
    // ==================================================
    // bus handshake: one wait cycle, answer on the second edge
    logic                 ack_r;
    logic                 req;
    logic                 wr_go;
    logic                 rd_go;
    logic [1:0]           lo_be;
    logic [15:0]          wmask;

    // stored fields
    logic [15:0]          trig_r;
    logic [1:0]           core_r;
    logic [13:0]          syspll_r;
    logic [13:0]          usbpll_r;

    // interrupt path
    logic [N_IRQ-1:0]     pin_d_r;
    logic [N_IRQ-1:0]     pend_r;
    logic [N_IRQ-1:0]     clr_hit;
    logic [N_IRQ-1:0]     edge_seen;
    logic [N_IRQ-1:0]     is_edge;
    logic [31:0]          rd_nxt;

    assign req   = avs_read | avs_write;
    assign wr_go = avs_write & ~ack_r;
    assign rd_go = avs_read & ~ack_r;
    assign lo_be = avs_byteenable[1:0];
    assign wmask = {{8{lo_be[1]}}, {8{lo_be[0]}}};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= req & ~ack_r;
        end
    end

    // registered so no combinational path runs back to the master's request
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            avs_waitrequest <= ~(req & ~ack_r);
        end
    end

    // ==================================================
    // trigger configuration
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            trig_r <= EICP_TRIG_RST;
        end
        else if (wr_go && avs_address == EICP_OFS_TRIG)
        begin
            trig_r <= (trig_r & ~wmask) | (avs_writedata[15:0] & wmask);
        end
    end

    // ==================================================
    // core clock mode
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            core_r <= EICP_CORE_RST;
        end
        else if (wr_go && avs_address == EICP_OFS_CORE && lo_be[0])
        begin
            core_r <= avs_writedata[1:0];
        end
    end

    // ==================================================
    // pll controls; bit 13 stored but never read back
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            syspll_r <= EICP_PLL_RST;
        end
        else if (wr_go && avs_address == EICP_OFS_SYSPLL)
        begin
            syspll_r <= (syspll_r & ~wmask[13:0]) | (avs_writedata[13:0] & wmask[13:0]);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            usbpll_r <= EICP_PLL_RST;
        end
        else if (wr_go && avs_address == EICP_OFS_USBPLL)
        begin
            usbpll_r <= (usbpll_r & ~wmask[13:0]) | (avs_writedata[13:0] & wmask[13:0]);
        end
    end

    // ==================================================
    // interrupt detection
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_d_r <= '1;
        end
        else
        begin
            pin_d_r <= ext_irq_pin;
        end
    end

    // ==================================================
    // clear decode
    // only bits 7 to 0 reach the clear logic
    assign clr_hit = (wr_go && avs_address == EICP_OFS_CLR && lo_be[0])
                     ? avs_writedata[N_IRQ-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < N_IRQ; gi++)
        begin : g_irq
            logic [1:0] mode;
            assign mode = trig_r[2*gi+1 -: 2];
            assign is_edge[gi] = mode[1];
            always_comb
            begin
                edge_seen[gi] = 1'b0;
                unique case (mode)
                    EICP_TRIG_FALL: edge_seen[gi] = pin_d_r[gi] & ~ext_irq_pin[gi];
                    EICP_TRIG_RISE: edge_seen[gi] = ~pin_d_r[gi] & ext_irq_pin[gi];
                    default:        edge_seen[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    // ==================================================
    // pending edge latch
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pend_r <= '0;
        end
        else
        begin
            // clear by writing one; a fresh edge wins over the clear
            // level inputs keep no pending state to clear
            pend_r <= ((pend_r & ~clr_hit) | edge_seen) & is_edge;
        end
    end

    // ==================================================
    // request: level inputs follow the live pin, not pin_d_r; edge inputs the latch
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ext_irq_request <= '0;
        else
        begin
            for (int i = 0; i < N_IRQ; i++)
            begin
                // level follows pin, edge holds until cleared
                unique case (trig_r[2*i+1 -: 2])
                    EICP_TRIG_LVL_LOW:
                    begin
                        ext_irq_request[i] <= ~ext_irq_pin[i];
                    end
                    EICP_TRIG_LVL_HIGH:
                    begin
                        ext_irq_request[i] <= ext_irq_pin[i];
                    end
                    EICP_TRIG_FALL,
                    EICP_TRIG_RISE:
                    begin
                        ext_irq_request[i] <= (pend_r[i] & ~clr_hit[i]) | edge_seen[i];
                    end
                endcase
            end
        end
    end

    // ==================================================
    // configuration outputs
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            core_clocking_select           <= EICP_CORE_RST;
            core_direct_bus_extension_mode <= 1'b0;
            core_std_sync_mode             <= 1'b0;
        end
        else
        begin
            core_clocking_select           <= core_r;
            // bit 0 set selects extension mode
            core_direct_bus_extension_mode <= core_r[0];
            core_std_sync_mode             <= (core_r == EICP_CORE_STD_SYNC);
        end
    end

    // the pll itself is outside; these fields set its ratio loop/pre
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            system_pll_range_select <= EICP_PLL_RST[EICP_PLL_RANGE_BIT];
            system_pll_pre_divider  <= EICP_PLL_RST[EICP_PLL_PRE_LSB +: EICP_PLL_FLD_W];
            system_pll_loop_divider <= EICP_PLL_RST[EICP_PLL_LOOP_LSB +: EICP_PLL_FLD_W];
        end
        else
        begin
            // system loop value passed as written
            system_pll_range_select <= syspll_r[EICP_PLL_RANGE_BIT];
            system_pll_pre_divider  <= syspll_r[EICP_PLL_PRE_LSB +: EICP_PLL_FLD_W];
            system_pll_loop_divider <= syspll_r[EICP_PLL_LOOP_LSB +: EICP_PLL_FLD_W];
        end
    end

    // usb copies; a zero divider is passed on, the pll side must tolerate it
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            usb_pll_range_select    <= EICP_PLL_RST[EICP_PLL_RANGE_BIT];
            usb_pll_pre_divider     <= EICP_PLL_RST[EICP_PLL_PRE_LSB +: EICP_PLL_FLD_W];
            usb_pll_loop_divider    <= EICP_PLL_RST[EICP_PLL_LOOP_LSB +: EICP_PLL_FLD_W];
        end
        else
        begin
            // usb loop value passed as written
            usb_pll_range_select    <= usbpll_r[EICP_PLL_RANGE_BIT];
            usb_pll_pre_divider     <= usbpll_r[EICP_PLL_PRE_LSB +: EICP_PLL_FLD_W];
            usb_pll_loop_divider    <= usbpll_r[EICP_PLL_LOOP_LSB +: EICP_PLL_FLD_W];
        end
    end

    // ==================================================
    // read mux
    always_comb
    begin
        rd_nxt = EICP_RD_UNMAPPED;
        unique case (avs_address)
            EICP_OFS_TRIG:   rd_nxt = {16'h0000, trig_r};
            EICP_OFS_SYSPLL: rd_nxt = {19'h0_0000, syspll_r[12:0]};
            EICP_OFS_USBPLL: rd_nxt = {19'h0_0000, usbpll_r[12:0]};
            // write-only registers read as zero
            EICP_OFS_CLR:    rd_nxt = EICP_RD_UNMAPPED;
            EICP_OFS_CORE:   rd_nxt = EICP_RD_UNMAPPED;
            default:         rd_nxt = EICP_RD_UNMAPPED;
        endcase
    end

    // ==================================================
    // read data held until the next read, so a slow master still sees it
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (rd_go)
        begin
            avs_readdata <= rd_nxt;
        end
    end
endmodule // eicp_top
`default_nettype wire

// ==== bench/eicp_irq_src.sv ====
// external interrupt sources that drive the eight interrupt pins
// assumes the pins are sampled on sys_clk and change just after an edge
`timescale 1ns/100ps
`default_nettype none
module eicp_irq_src
(
    input  wire logic       sys_clk,
    output var  logic [7:0] ext_irq_pin
);
    initial ext_irq_pin = 8'h00;
    // ==================================================
    // pins move right after an edge so no sample races them
    task automatic set_pins(input logic [7:0] v);
        @(posedge sys_clk);
        ext_irq_pin <= v;
    endtask
endmodule // eicp_irq_src
`default_nettype wire

// ==== bench/eicp_top_asserts.sv ====
// checker for the register bank handshake, mode decode and interrupt requests
// assumes it is bound to eicp_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module eicp_top_asserts
    import eicp_pkg::*;
#(
    parameter int N_IRQ = 8
)(
    input wire logic             sys_clk,
    input wire logic             rst,
    input wire logic [7:0]       avs_address,
    input wire logic             avs_read,
    input wire logic             avs_write,
    input wire logic [31:0]      avs_writedata,
    input wire logic [31:0]      avs_readdata,
    input wire logic             avs_waitrequest,
    input wire logic [N_IRQ-1:0] ext_irq_pin,
    input wire logic [N_IRQ-1:0] ext_irq_request,
    input wire logic [1:0]       core_clocking_select,
    input wire logic             core_direct_bus_extension_mode,
    input wire logic             core_std_sync_mode,
    input wire logic             system_pll_range_select,
    input wire logic [5:0]       system_pll_loop_divider,
    input wire logic [5:0]       system_pll_pre_divider
);
    // ==================================================
    // shadow of the trigger setting, from writes as they are taken
    logic [15:0] cfg_r;
    always_ff @(posedge sys_clk)
        if (rst)
            cfg_r <= EICP_TRIG_RST;
        else if (avs_write && avs_waitrequest && avs_address == EICP_OFS_TRIG)
            cfg_r <= avs_writedata[15:0];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ==================================================
    AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered after one wait cycle");
    AST_SHORT_ACK: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_EXT_BIT: assert property (core_direct_bus_extension_mode == core_clocking_select[0])
        else $error("extension mode not equal to field bit zero");
    AST_SYNC_DEC: assert property (core_std_sync_mode == (core_clocking_select == 2'h2))
        else $error("sync mode decode wrong");
    AST_CLR_RD: assert property (avs_read && !avs_waitrequest && avs_address == EICP_OFS_CLR
        |-> avs_readdata == 32'h0000_0000) else $error("clear register read not zero");
    AST_USB_HI: assert property (avs_read && !avs_waitrequest && avs_address == EICP_OFS_USBPLL
        |-> avs_readdata[31:14] == 18'h0_0000) else $error("usb pll upper bits not zero");
    AST_PLL_WR: assert property (avs_write && !avs_waitrequest && avs_address == EICP_OFS_SYSPLL
        |=> system_pll_loop_divider == $past(avs_writedata[5:0], 2)
        && system_pll_pre_divider == $past(avs_writedata[11:6], 2)
        && system_pll_range_select == $past(avs_writedata[12], 2))
        else $error("system pll fields not copied from the write");
    AST_LVL_HIGH: assert property ((cfg_r[1:0] == EICP_TRIG_LVL_HIGH && $stable(ext_irq_pin[0]))[*3]
        |-> ext_irq_request[0] == ext_irq_pin[0]) else $error("high level request wrong");
    AST_LVL_LOW: assert property ((cfg_r[3:2] == EICP_TRIG_LVL_LOW && $stable(ext_irq_pin[1]))[*3]
        |-> ext_irq_request[1] == !ext_irq_pin[1]) else $error("low level request wrong");
    AST_EDGE_HOLD: assert property (cfg_r[1:0] == EICP_TRIG_RISE && ext_irq_request[0] && !avs_write
        |=> ext_irq_request[0]) else $error("pending edge request lost");
endmodule // eicp_top_asserts
bind eicp_top eicp_top_asserts #(.N_IRQ(N_IRQ)) chk (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_irq_pin(ext_irq_pin),
    .ext_irq_request(ext_irq_request), .core_clocking_select(core_clocking_select),
    .core_direct_bus_extension_mode(core_direct_bus_extension_mode),
    .core_std_sync_mode(core_std_sync_mode), .system_pll_range_select(system_pll_range_select),
    .system_pll_loop_divider(system_pll_loop_divider),
    .system_pll_pre_divider(system_pll_pre_divider));
`default_nettype wire

// ==== bench/extint_core_pll_config_bench.sv ====
// self-checking bench for the register bank over avalon-mm
// assumes eicp_top, its checker and the interrupt source model are compiled first
`timescale 1ns/100ps
`default_nettype none
module extint_core_pll_config_bench
    import eicp_pkg::*;
;
    logic        sys_clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_address, ext_irq_pin, ext_irq_request;
    logic [31:0] avs_writedata, avs_readdata;
    logic [1:0]  core_sel;
    logic        ext_mode, sync_mode, sys_rng, usb_rng;
    logic [5:0]  sys_pre, sys_loop, usb_pre, usb_loop;
    int          failures, check_count, cyc;
    eicp_top #(.N_IRQ(8)) dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_irq_pin(ext_irq_pin), .ext_irq_request(ext_irq_request),
        .core_clocking_select(core_sel), .core_direct_bus_extension_mode(ext_mode),
        .core_std_sync_mode(sync_mode), .system_pll_range_select(sys_rng),
        .system_pll_pre_divider(sys_pre), .system_pll_loop_divider(sys_loop),
        .usb_pll_range_select(usb_rng), .usb_pll_pre_divider(usb_pre),
        .usb_pll_loop_divider(usb_loop));
    eicp_irq_src src (.sys_clk(sys_clk), .ext_irq_pin(ext_irq_pin));
    // ==================================================
    // shared helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // extra edge lets registered copies and clears land
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        @(posedge sys_clk);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(nm, q, e);
    endtask
    task automatic pins(input logic [7:0] v);
        src.set_pins(v);
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic req(input logic [7:0] e);
        chk("ext_irq_request", 32'(ext_irq_request), 32'(e));
    endtask
    // ==================================================
    // scenarios
    task automatic t_reset();
        rd("trig", EICP_OFS_TRIG, 32'h0000_0000);
        rd("clr", EICP_OFS_CLR, 32'h0000_0000);
        rd("sys", EICP_OFS_SYSPLL, 32'h0000_0045);
        rd("usb", EICP_OFS_USBPLL, 32'h0000_0045);
        rd("hole", 8'h8c, 32'h0000_0000);
        chk("usb_loop", 32'(usb_loop), 32'h0000_0005);
    endtask
    task automatic t_level();
        wr(EICP_OFS_TRIG, 32'h0000_5555);
        pins(8'ha5);
        req(8'ha5);
        wr(EICP_OFS_TRIG, 32'h0000_4444);
        pins(8'h00);
        req(8'h55);
        wr(EICP_OFS_CLR, 32'h0000_00ff);
        req(8'h55);
        rd("trig", EICP_OFS_TRIG, 32'h0000_4444);
    endtask
    task automatic t_edge();
        wr(EICP_OFS_CLR, 32'h0000_00ff);
        wr(EICP_OFS_TRIG, 32'h0000_ffff);
        pins(8'h00);
        req(8'h00);
        pins(8'hff);
        req(8'hff);
        pins(8'h00);
        req(8'hff);
        wr(EICP_OFS_CLR, 32'hffff_ff0f);
        req(8'hf0);
        wr(EICP_OFS_CLR, 32'h0000_0000);
        req(8'hf0);
        wr(EICP_OFS_CLR, 32'h0000_00ff);
        wr(EICP_OFS_TRIG, 32'h0000_aaaa);
        pins(8'hff);
        req(8'h00);
        pins(8'h00);
        req(8'hff);
    endtask
    task automatic t_core();
        logic [1:0] m;
        for (int i = 0; i < 4; i++)
        begin
            m = 2'(i);
            wr(EICP_OFS_CORE, 32'(m));
            chk("core_sel", 32'(core_sel), 32'(m));
            chk("ext_mode", 32'(ext_mode), 32'(m[0]));
            chk("sync_mode", 32'(sync_mode), 32'(m == 2'h2));
        end
        rd("core", EICP_OFS_CORE, 32'h0000_0000);
    endtask
    task automatic t_pll();
        wr(EICP_OFS_SYSPLL, 32'hffff_3fff);
        rd("sys", EICP_OFS_SYSPLL, 32'h0000_1fff);
        chk("sys_rng", 32'(sys_rng), 32'h0000_0001);
        chk("sys_loop", 32'(sys_loop), 32'h0000_003f);
        wr(EICP_OFS_USBPLL, 32'hffff_2081);
        rd("usb", EICP_OFS_USBPLL, 32'h0000_0081);
        chk("usb_pre", 32'(usb_pre), 32'h0000_0002);
        chk("usb_loop", 32'(usb_loop), 32'h0000_0001);
        chk("usb_rng", 32'(usb_rng), 32'h0000_0000);
        wr(EICP_OFS_USBPLL, 32'h0000_3041);
        chk("usb_rng", 32'(usb_rng), 32'h0000_0001);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ==================================================
    // clock, watchdog and main sequence
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            results();
        end
    end
    initial
    begin
        {rst, avs_read, avs_write, avs_address, avs_writedata} = {3'b100, 40'h00_0000_0000};
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_level();
        t_edge();
        t_core();
        t_pll();
        results();
    end
endmodule // extint_core_pll_config_bench
`default_nettype wire
